// [pesg_regs.svh]
`ifndef PESG_REGS_SVH
`define PESG_REGS_SVH

// Suspend opcodes
`define PESG_OP_SUSPEND_A    8'h75
`define PESG_OP_SUSPEND_B    8'hB0
// Status reads
`define PESG_OP_RD_SR1       8'h05
`define PESG_OP_RD_SR2       8'h35
`define PESG_OP_RD_SR3       8'h15
`define PESG_OP_RD_SR_IND    8'h65
// Always-permitted housekeeping
`define PESG_OP_ACT_INT      8'h25
`define PESG_OP_TERMINATE    8'hF0
`define PESG_OP_EN_RESET     8'h66
`define PESG_OP_RESET        8'h99
`define PESG_OP_ID_A         8'h9F
`define PESG_OP_ID_B         8'h90
`define PESG_OP_ID_C         8'h94
`define PESG_OP_DPD_EXIT     8'hAB
// Array and buffer reads
`define PESG_OP_RD_A         8'h03
`define PESG_OP_RD_B         8'h0B
`define PESG_OP_RD_C         8'h3B
`define PESG_OP_RD_D         8'h6B
`define PESG_OP_RD_E         8'hEB
`define PESG_OP_RD_F         8'hE7
`define PESG_OP_BUF_RD       8'hD4
// Resume, write enable group
`define PESG_OP_RESUME_A     8'h7A
`define PESG_OP_RESUME_B     8'hD0
`define PESG_OP_WR_EN        8'h06
`define PESG_OP_WR_DIS       8'h04
`define PESG_OP_VOL_WR_EN    8'h50
// Lock status, OTP read, discovery, burst, battery
`define PESG_OP_LOCK_RD_A    8'h3C
`define PESG_OP_LOCK_RD_B    8'h3D
`define PESG_OP_OTP_RD       8'h4B
`define PESG_OP_SFDP         8'h5A
`define PESG_OP_BURST_WRAP   8'h77
`define PESG_OP_LOW_BATT     8'hEF
// Program-type commands
`define PESG_OP_BUF_WR       8'h84
`define PESG_OP_PROG_A       8'h02
`define PESG_OP_PROG_B       8'hA2
`define PESG_OP_PROG_C       8'h32
`define PESG_OP_BUF_PROG     8'h88
`define PESG_OP_SEQ_A        8'hAD
`define PESG_OP_SEQ_B        8'hAF

// Synchroniser depths: frame end lags opcode data so data settles first
`define PESG_SYNC_DATA       3
`define PESG_SYNC_FRAME      4
// Bits per opcode
`define PESG_OP_BITS         8

`endif

// [pesg_pkg.sv]
package pesg_pkg;

	typedef enum logic [1:0] {
		PESG_ST_IDLE  = 2'b00,
		PESG_ST_BUSY  = 2'b01,
		PESG_ST_PSUSP = 2'b10,
		PESG_ST_ESUSP = 2'b11
	} pesg_state_t;

endpackage : pesg_pkg

// [pesg_sync.sv]
`timescale 1ns/100ps
`default_nettype none

module pesg_sync #(
	parameter int WIDTH  = 1,
	parameter int STAGES = 2
) (
	// Clock and reset
	input  wire logic             clk_i,
	input  wire logic             rst_n_i,
	// Data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
		$error("pesg_sync: needs WIDTH >= 1 and STAGES >= 2");
	end

	logic [WIDTH-1:0] chain_reg [STAGES];

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < STAGES; i++) begin
				chain_reg[i] <= '0;
			end
		end else begin
			chain_reg[0] <= d_i;
			for (int i = 1; i < STAGES; i++) begin
				chain_reg[i] <= chain_reg[i-1];
			end
		end
	end

	assign q_o = chain_reg[STAGES-1];

endmodule : pesg_sync

`default_nettype wire

// [pesg_gate.sv]
// Overview of operation
// R1: Opcodes 75h and B0h both request suspend.
// R2: Valid suspend pauses running program or erase.
// R3: Suspend is opcode only, no address/data; code still suspends when trailing bits are a multiple of eight.
// R4: Opcode shifted in eight clocks, MSB first.
// R5: Suspend starts only at chip-select deassertion.
// R6: Disallowed commands are discarded, no operation.
// R7: Rejection leaves write enable latch untouched.
// R8: Filter state from busy, PS, ES flags.
// R9: While busy: only suspend and status reads; code also admits the always-permitted housekeeping opcodes.
// R10: Program suspend: reads, resume, WE, status allowed.
// R11: Erase suspend adds program commands; no resuspend.
// R12: Erase, lock, OTP program, status writes rejected.
// R13: Erase-suspend programs target another 64 kB block; code does not check the block and leaves it to the datapath.
// R14: Suspend done sets ANY_SUSPEND_FLAG, PS/ES; clears busy.
// R15: Short or misaligned frame performs no suspend.
// R16: Suspend ignores write enable latch state.
// R17: Suspend when idle does nothing.
`include "pesg_regs.svh"
`timescale 1ns/100ps
`default_nettype none

module pesg_gate (
	// System clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       rst_n_i,
	// Serial link from host
	input  wire logic       spi_sck_i,
	input  wire logic       spi_cs_n_i,
	input  wire logic       spi_si_i,
	// Array core status
	input  wire logic       core_busy_i,
	input  wire logic       core_op_is_erase_i,
	input  wire logic       core_op_unsuspendable_i,
	input  wire logic       suspend_ack_i,
	input  wire logic       resume_done_i,
	// Command decision to datapaths
	output logic      [7:0] cmd_opcode_o,
	output logic            cmd_accept_o,
	output logic            cmd_reject_o,
	// Suspend request to array core
	output logic            suspend_req_o,
	// Status flags
	output logic            device_busy_flag_o,
	output logic            program_suspended_flag_o,
	output logic            erase_suspended_flag_o,
	output logic            any_suspend_flag_o
);

	// ------------------------------------------------------------------
	// Link domain: opcode assembly on the host's serial clock
	// ------------------------------------------------------------------
	logic       new_frame_reg;
	logic [2:0] bit_cnt_reg;
	logic       op_done_reg;
	logic [7:0] op_shift_reg;
	logic       op_evt_tgl_reg;

	// Armed asynchronously while chip select is high, so the first edge of
	// a frame knows to restart; the sampled data stays put for the
	// system side to read once the frame is over.
	always_ff @(posedge spi_sck_i or posedge spi_cs_n_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			new_frame_reg <= 1'b1;
		end else if (spi_cs_n_i) begin
			new_frame_reg <= 1'b1;
		end else begin
			new_frame_reg <= 1'b0;
		end
	end

	always_ff @(posedge spi_sck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bit_cnt_reg <= 3'h0;
		end else if (new_frame_reg) begin
			bit_cnt_reg <= 3'h1;
		end else begin
			bit_cnt_reg <= bit_cnt_reg + 3'h1; // R15
		end
	end

	always_ff @(posedge spi_sck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_shift_reg <= 8'h00;
		end else if (new_frame_reg) begin
			op_shift_reg <= {7'h00, spi_si_i}; // R4
		end else if (!op_done_reg) begin
			op_shift_reg <= {op_shift_reg[6:0], spi_si_i}; // R4
		end
	end

	always_ff @(posedge spi_sck_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			op_done_reg    <= 1'b0;
			op_evt_tgl_reg <= 1'b0;
		end else if (new_frame_reg) begin
			op_done_reg <= 1'b0;
		end else if (!op_done_reg && bit_cnt_reg == 3'h7) begin
			// Eighth bit lands this edge: opcode complete
			op_done_reg    <= 1'b1;
			op_evt_tgl_reg <= ~op_evt_tgl_reg; // R4
		end
	end

	// ------------------------------------------------------------------
	// Crossings into the system domain
	// ------------------------------------------------------------------
	logic [7:0] op_sync;
	logic [2:0] cnt_sync;
	logic       tgl_sync;
	logic       cs_n_sync;
	logic       cs_act_sync;

	pesg_sync #(
		.WIDTH  (11),
		.STAGES (`PESG_SYNC_DATA)
	) u_sync_data (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     ({op_shift_reg, bit_cnt_reg}),
		.q_o     ({op_sync, cnt_sync})
	);

	// Toggle goes one stage deeper than the opcode bits it announces
	pesg_sync #(
		.WIDTH  (1),
		.STAGES (`PESG_SYNC_DATA + 1)
	) u_sync_tgl (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (op_evt_tgl_reg),
		.q_o     (tgl_sync)
	);

	// Frame end is seen last, after any opcode event of that frame
	pesg_sync #(
		.WIDTH  (1),
		.STAGES (`PESG_SYNC_FRAME + 1)
	) u_sync_cs (
		.clk_i   (sys_clk_i),
		.rst_n_i (rst_n_i),
		.d_i     (~spi_cs_n_i),
		.q_o     (cs_act_sync)
	);

	// Carried as select-active so the chain's reset zero reads as idle;
	// otherwise a false frame start and end would follow every reset
	assign cs_n_sync = ~cs_act_sync;

	logic tgl_seen_reg;
	logic cs_n_seen_reg;
	logic op_evt;
	logic frame_end;
	logic frame_start;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tgl_seen_reg  <= 1'b0;
			cs_n_seen_reg <= 1'b1;
		end else begin
			tgl_seen_reg  <= tgl_sync;
			cs_n_seen_reg <= cs_n_sync;
		end
	end

	assign op_evt      = tgl_sync ^ tgl_seen_reg;
	assign frame_end   = cs_n_sync & ~cs_n_seen_reg;
	assign frame_start = ~cs_n_sync & cs_n_seen_reg;

	// ------------------------------------------------------------------
	// Filter state
	// ------------------------------------------------------------------
	logic                ps_reg;
	logic                es_reg;
	logic                busy_reg;
	pesg_pkg::pesg_state_t state;

	always_comb begin
		if (busy_reg) begin
			state = pesg_pkg::PESG_ST_BUSY; // R8
		end else if (ps_reg) begin
			state = pesg_pkg::PESG_ST_PSUSP; // R8
		end else if (es_reg) begin
			state = pesg_pkg::PESG_ST_ESUSP; // R8
		end else begin
			state = pesg_pkg::PESG_ST_IDLE;
		end
	end

	function automatic logic is_suspend(input logic [7:0] op);
		is_suspend = (op == `PESG_OP_SUSPEND_A) || (op == `PESG_OP_SUSPEND_B); // R1
	endfunction : is_suspend

	// Permitted in every filtered state
	function automatic logic ok_always(input logic [7:0] op);
		case (op)
			`PESG_OP_RD_SR1, `PESG_OP_RD_SR2, `PESG_OP_RD_SR3, `PESG_OP_RD_SR_IND,
			`PESG_OP_ACT_INT, `PESG_OP_TERMINATE, `PESG_OP_EN_RESET, `PESG_OP_RESET,
			`PESG_OP_ID_A, `PESG_OP_ID_B, `PESG_OP_ID_C, `PESG_OP_DPD_EXIT:
				ok_always = 1'b1;
			default:
				ok_always = 1'b0;
		endcase
	endfunction : ok_always

	// Permitted in either suspended state
	function automatic logic ok_any_suspend_flag(input logic [7:0] op);
		case (op)
			`PESG_OP_RD_A, `PESG_OP_RD_B, `PESG_OP_RD_C, `PESG_OP_RD_D,
			`PESG_OP_RD_E, `PESG_OP_RD_F, `PESG_OP_BUF_RD,
			`PESG_OP_RESUME_A, `PESG_OP_RESUME_B,
			`PESG_OP_WR_EN, `PESG_OP_WR_DIS, `PESG_OP_VOL_WR_EN,
			`PESG_OP_LOCK_RD_A, `PESG_OP_LOCK_RD_B, `PESG_OP_OTP_RD,
			`PESG_OP_SFDP, `PESG_OP_BURST_WRAP, `PESG_OP_LOW_BATT:
				ok_any_suspend_flag = 1'b1;
			default:
				ok_any_suspend_flag = 1'b0;
		endcase
	endfunction : ok_any_suspend_flag

	// Extra program-type commands during erase suspend; block target is
	// the datapath's to police
	function automatic logic ok_esusp(input logic [7:0] op);
		case (op)
			`PESG_OP_BUF_WR, `PESG_OP_PROG_A, `PESG_OP_PROG_B, `PESG_OP_PROG_C,
			`PESG_OP_BUF_PROG, `PESG_OP_SEQ_A, `PESG_OP_SEQ_B:
				ok_esusp = 1'b1; // R11 R13
			default:
				ok_esusp = 1'b0;
		endcase
	endfunction : ok_esusp

	// Erase, lock, OTP program, status writes fall to default: rejected
	logic allowed;

	always_comb begin
		case (state)
			pesg_pkg::PESG_ST_IDLE:
				allowed = 1'b1;
			pesg_pkg::PESG_ST_BUSY:
				allowed = is_suspend(op_sync) || ok_always(op_sync); // R9 R12
			pesg_pkg::PESG_ST_PSUSP:
				allowed = ok_always(op_sync) || ok_any_suspend_flag(op_sync); // R10 R12
			pesg_pkg::PESG_ST_ESUSP:
				allowed = ok_always(op_sync) || ok_any_suspend_flag(op_sync) || ok_esusp(op_sync); // R11 R12
			default:
				allowed = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Command decision
	// ------------------------------------------------------------------
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cmd_opcode_o <= 8'h00;
			cmd_accept_o <= 1'b0;
			cmd_reject_o <= 1'b0;
		end else begin
			cmd_accept_o <= op_evt && allowed;
			// No accept pulse means no datapath, so the write latch holds
			cmd_reject_o <= op_evt && !allowed; // R6 R7
			if (op_evt) begin
				cmd_opcode_o <= op_sync;
			end
		end
	end

	// Opcode of this frame was a suspend taken by the filter
	logic any_suspend_flag_armed_reg;

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			any_suspend_flag_armed_reg <= 1'b0;
		end else if (frame_start || frame_end) begin
			any_suspend_flag_armed_reg <= 1'b0;
		end else if (op_evt) begin
			// Write enable latch deliberately not consulted
			any_suspend_flag_armed_reg <= is_suspend(op_sync) && allowed; // R1 R16
		end
	end

	// ------------------------------------------------------------------
	// Suspend execution
	// ------------------------------------------------------------------
	logic any_suspend_flag_pend_reg;
	logic pend_erase_reg;
	logic any_suspend_flag_go;

	// Count of 0 mod 8 with an opcode seen: trailing bits break it unless they are a multiple of eight
	assign any_suspend_flag_go = frame_end && any_suspend_flag_armed_reg && (cnt_sync == 3'h0) // R3 R5 R15
		&& busy_reg && !core_op_unsuspendable_i && !any_suspend_flag_pend_reg; // R17

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			suspend_req_o  <= 1'b0;
			any_suspend_flag_pend_reg  <= 1'b0;
			pend_erase_reg <= 1'b0;
		end else begin
			suspend_req_o <= any_suspend_flag_go; // R2 R5
			if (any_suspend_flag_go) begin
				any_suspend_flag_pend_reg  <= 1'b1;
				pend_erase_reg <= core_op_is_erase_i;
			end else if (suspend_ack_i) begin
				any_suspend_flag_pend_reg <= 1'b0;
			end
		end
	end

	logic any_suspend_flag_done;

	assign any_suspend_flag_done = any_suspend_flag_pend_reg && suspend_ack_i;

	// Set wins over a resume clear landing in the same cycle
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ps_reg <= 1'b0;
			es_reg <= 1'b0;
		end else if (any_suspend_flag_done) begin
			if (pend_erase_reg) begin
				es_reg <= 1'b1; // R14
			end else begin
				ps_reg <= 1'b1; // R14
			end
		end else if (resume_done_i) begin
			if (ps_reg) begin
				ps_reg <= 1'b0;
			end else begin
				es_reg <= 1'b0;
			end
		end
	end

	// Busy drops as soon as the suspend is pending, before the core acknowledges
	// it or its own busy is observed low again
	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_reg <= 1'b0;
		end else begin
			busy_reg <= core_busy_i && !any_suspend_flag_done && !any_suspend_flag_pend_reg; // R14
		end
	end

	always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			device_busy_flag_o       <= 1'b0;
			program_suspended_flag_o <= 1'b0;
			erase_suspended_flag_o   <= 1'b0;
			any_suspend_flag_o       <= 1'b0;
		end else begin
			device_busy_flag_o       <= busy_reg;
			program_suspended_flag_o <= ps_reg;
			erase_suspended_flag_o   <= es_reg;
			any_suspend_flag_o       <= ps_reg || es_reg; // R14
		end
	end

endmodule : pesg_gate

`default_nettype wire

// [pesg_gate_sva.sv]
`timescale 1ns/100ps
`default_nettype none

module pesg_gate_sva (
	// Clock and reset
	input wire logic       sys_clk_i,
	input wire logic       rst_n_i,
	// Link and core
	input wire logic       spi_sck_i,
	input wire logic       spi_cs_n_i,
	input wire logic       spi_si_i,
	input wire logic       core_busy_i,
	input wire logic       core_op_is_erase_i,
	input wire logic       core_op_unsuspendable_i,
	input wire logic       suspend_ack_i,
	input wire logic       resume_done_i,
	// Outputs watched
	input wire logic [7:0] cmd_opcode_o,
	input wire logic       cmd_accept_o,
	input wire logic       cmd_reject_o,
	input wire logic       suspend_req_o,
	input wire logic       device_busy_flag_o,
	input wire logic       program_suspended_flag_o,
	input wire logic       erase_suspended_flag_o,
	input wire logic       any_suspend_flag_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);

	AST_ACC_REJ_EXCL: assert property (!(cmd_accept_o && cmd_reject_o))
		else $error("accept and reject together");
	AST_SREQ_PULSE: assert property (suspend_req_o |=> !suspend_req_o)
		else $error("suspend request longer than one cycle");
	AST_SREQ_CS_HIGH: assert property (suspend_req_o |-> spi_cs_n_i && $past(spi_cs_n_i, 4))
		else $error("suspend request before chip select rose");
	AST_SREQ_BUSY_DROP: assert property (suspend_req_o |-> ##2 !device_busy_flag_o)
		else $error("busy flag not cleared after suspend");
	AST_SREQ_LOCKED: assert property (suspend_req_o |-> !$past(core_op_unsuspendable_i))
		else $error("suspend issued to unsuspendable operation");
	AST_IDLE_NO_SREQ: assert property (suspend_req_o |-> device_busy_flag_o)
		else $error("suspend issued while idle");
	AST_ANY_FLAG: assert property (any_suspend_flag_o == (program_suspended_flag_o || erase_suspended_flag_o))
		else $error("any suspend flag mismatch");
	AST_ANY_SUSPEND_FLAG_SET: assert property ($rose(any_suspend_flag_o) |-> $past(suspend_ack_i, 2))
		else $error("suspend flag set without acknowledge");
	AST_ES_KIND: assert property ($rose(erase_suspended_flag_o) |-> $past(core_op_is_erase_i, 2))
		else $error("erase suspend flag for program");

	cover property (suspend_req_o);
	cover property ($rose(program_suspended_flag_o));
	cover property ($rose(erase_suspended_flag_o));
	cover property (cmd_reject_o);
endmodule : pesg_gate_sva

bind pesg_gate pesg_gate_sva pesg_gate_sva_i (.sys_clk_i, .rst_n_i, .spi_sck_i, .spi_cs_n_i,
	.spi_si_i, .core_busy_i, .core_op_is_erase_i, .core_op_unsuspendable_i, .suspend_ack_i,
	.resume_done_i, .cmd_opcode_o, .cmd_accept_o, .cmd_reject_o, .suspend_req_o,
	.device_busy_flag_o, .program_suspended_flag_o, .erase_suspended_flag_o,
	.any_suspend_flag_o);

`default_nettype wire

// [pesg_host_model.sv]
`timescale 1ns/100ps
`default_nettype none

module pesg_host_model (
	// Serial link to device
	output logic spi_sck_o,
	output logic spi_cs_n_o,
	output logic spi_si_o
);
	initial begin
		spi_sck_o = 1'b0;
		spi_cs_n_o = 1'b1;
		spi_si_o = 1'b1;
	end

	// Clock parked low outside frames; odd offset keeps phase unrelated
	task automatic send(input logic [15:0] bits, input int n);
		#3 spi_cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			spi_si_o = bits[15 - i];
			#80 spi_sck_o = 1'b1;
			#80 spi_sck_o = 1'b0;
		end
		#80 spi_cs_n_o = 1'b1;
		// Released line must not hold its last bit
		spi_si_o = ~spi_si_o;
	endtask : send
endmodule : pesg_host_model

`default_nettype wire

// [pesg_gate_tb_top.sv]
`timescale 1ns/100ps
`default_nettype none

module pesg_gate_tb_top;
	logic       sys_clk_i = 1'b0;
	logic       rst_n_i = 1'b0;
	wire        spi_sck_i;
	wire        spi_cs_n_i;
	wire        spi_si_i;
	logic       core_busy_i = 1'b0;
	logic       core_op_is_erase_i = 1'b0;
	logic       core_op_unsuspendable_i = 1'b0;
	logic       suspend_ack_i = 1'b0;
	logic       resume_done_i = 1'b0;
	logic [7:0] cmd_opcode_o;
	logic       cmd_accept_o;
	logic       cmd_reject_o;
	logic       suspend_req_o;
	logic       device_busy_flag_o;
	logic       program_suspended_flag_o;
	logic       erase_suspended_flag_o;
	logic       any_suspend_flag_o;
	int         error_cnt = 0;
	int         num_checks = 0;
	// Opcode, then allowed mask: busy, program suspend, erase suspend
	logic [11:0] tbl [28] = '{12'h057, 12'h657, 12'h257, 12'hF07, 12'h9F7, 12'hAB7,
		12'h033, 12'hD43, 12'h7A3, 12'hD03, 12'h063, 12'h043, 12'h503, 12'h3C3,
		12'h4B3, 12'h5A3, 12'hEF3, 12'h841, 12'h021, 12'h881, 12'hAD1, 12'h810,
		12'h600, 12'h0A0, 12'h360, 12'h7E0, 12'h9B0, 12'h010};

	always #5 sys_clk_i = ~sys_clk_i;

	pesg_host_model pesg_host_model_i (.spi_sck_o(spi_sck_i), .spi_cs_n_o(spi_cs_n_i),
		.spi_si_o(spi_si_i));

	pesg_gate pesg_gate_i (.sys_clk_i, .rst_n_i, .spi_sck_i, .spi_cs_n_i, .spi_si_i,
		.core_busy_i, .core_op_is_erase_i, .core_op_unsuspendable_i, .suspend_ack_i,
		.resume_done_i, .cmd_opcode_o, .cmd_accept_o, .cmd_reject_o, .suspend_req_o,
		.device_busy_flag_o, .program_suspended_flag_o, .erase_suspended_flag_o,
		.any_suspend_flag_o);

	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, g);
		end
	endtask : chk

	// Answer code: 1 accept, 2 reject, 0 none
	task automatic cmd(input logic [7:0] op, input int n, input logic [1:0] ea, input logic es);
		logic [1:0] got;
		logic       sr;
		got = 2'b00;
		sr = 1'b0;
		fork
			pesg_host_model_i.send({op, 8'h00}, n);
			repeat (300) begin
				@(negedge sys_clk_i);
				if (got === 2'b00)
					got = {cmd_reject_o, cmd_accept_o};
				sr = sr | suspend_req_o;
			end
		join
		chk("answer", {6'h00, ea}, {6'h00, got});
		if (ea == 2'b01)
			chk("opcode", op, cmd_opcode_o);
		chk("suspend_req", {7'h00, es}, {7'h00, sr});
	endtask : cmd

	task automatic flags(input logic [2:0] e);
		@(negedge sys_clk_i);
		chk("flags", {4'h0, e, e[1] | e[0]}, {4'h0, device_busy_flag_o,
			program_suspended_flag_o, erase_suspended_flag_o, any_suspend_flag_o});
	endtask : flags

	task automatic sweep(input int b);
		for (int k = 0; k < 28; k++)
			cmd(tbl[k][11:4], 8, tbl[k][b] ? 2'b01 : 2'b10, 1'b0);
	endtask : sweep

	task automatic suspend(input logic [7:0] op, input logic er);
		@(posedge sys_clk_i);
		core_busy_i <= 1'b1;
		core_op_is_erase_i <= er;
		cmd(op, 8, 2'b01, 1'b1);
		@(posedge sys_clk_i);
		suspend_ack_i <= 1'b1;
		core_busy_i <= 1'b0;
		@(posedge sys_clk_i);
		suspend_ack_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		flags({1'b0, ~er, er});
	endtask : suspend

	task automatic resume();
		@(posedge sys_clk_i);
		resume_done_i <= 1'b1;
		@(posedge sys_clk_i);
		resume_done_i <= 1'b0;
		repeat (3) @(posedge sys_clk_i);
		flags(3'b000);
	endtask : resume

	task automatic close_out();
		$display("Checks %0d errors %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : close_out

	initial begin
		repeat (3) @(posedge sys_clk_i);
		rst_n_i <= 1'b1;
		repeat (6) @(posedge sys_clk_i);
		cmd(8'h75, 8, 2'b01, 1'b0);
		flags(3'b000);
		@(posedge sys_clk_i);
		core_busy_i <= 1'b1;
		sweep(2);
		@(posedge sys_clk_i);
		core_op_unsuspendable_i <= 1'b1;
		cmd(8'h75, 8, 2'b01, 1'b0);
		@(posedge sys_clk_i);
		core_op_unsuspendable_i <= 1'b0;
		cmd(8'h75, 12, 2'b01, 1'b0);
		cmd(8'hB0, 5, 2'b00, 1'b0);
		suspend(8'hB0, 1'b0);
		sweep(1);
		cmd(8'h75, 8, 2'b10, 1'b0);
		resume();
		suspend(8'h75, 1'b1);
		sweep(0);
		cmd(8'hB0, 16, 2'b10, 1'b0);
		resume();
		close_out();
	end
endmodule : pesg_gate_tb_top

`default_nettype wire
